// file: core/dbgbp_pkg.sv
`default_nettype none

package dbgbp_pkg;

    localparam int unsigned ADDR_W = 16;
    localparam int unsigned SCR_W  = 8;
    localparam int unsigned CODE_W = 8;
    localparam int unsigned DATA_W = 16;

    // Bit positions in debug_status_control
    localparam int unsigned BIT_PERMIT          = 7;
    localparam int unsigned BIT_ACTIVE          = 6;
    localparam int unsigned BIT_BKPT_ENABLE     = 5;
    localparam int unsigned BIT_FORCE_TAG       = 4;
    localparam int unsigned BIT_CLK_SEL         = 3;
    localparam int unsigned BIT_WAIT_STOP       = 2;
    localparam int unsigned BIT_WAIT_STOP_FAIL  = 1;
    localparam int unsigned BIT_DATA_VALID_FAIL = 0;

    localparam logic [SCR_W-1:0]  SCR_RESET   = 8'h00;
    localparam logic [ADDR_W-1:0] MATCH_RESET = 16'h0000;

    // Serial command codes handled here
    localparam logic [CODE_W-1:0] CMD_BACKGROUND    = 8'h90;
    localparam logic [CODE_W-1:0] CMD_READ_STATUS   = 8'hE4;
    localparam logic [CODE_W-1:0] CMD_WRITE_CONTROL = 8'hC4;
    localparam logic [CODE_W-1:0] CMD_READ_MATCH    = 8'hE2;
    localparam logic [CODE_W-1:0] CMD_WRITE_MATCH   = 8'hC2;

    localparam int unsigned QUEUE_DEPTH = 3;

endpackage : dbgbp_pkg

`default_nettype wire

// file: core/dbgbp_link_if.sv
`default_nettype none

interface dbgbp_link_if;
    logic                        cmd_valid;
    logic [dbgbp_pkg::CODE_W-1:0] cmd_code;
    logic                        do_bgnd;
    logic                        do_rd_status;
    logic                        do_wr_ctrl;
    logic                        do_rd_match;
    logic                        do_wr_match;
    logic [dbgbp_pkg::ADDR_W-1:0] match_addr;
    logic                        bp_enable;
    logic                        force_tag_select;
    logic                        force_hit;
    logic                        tag_hit;

    modport ctl (output cmd_valid, cmd_code, match_addr, bp_enable, force_tag_select,
                 input do_bgnd, do_rd_status, do_wr_ctrl, do_rd_match, do_wr_match,
                 input force_hit, tag_hit);
    modport dec (input cmd_valid, cmd_code,
                 output do_bgnd, do_rd_status, do_wr_ctrl, do_rd_match, do_wr_match);
    modport bp  (input match_addr, bp_enable, force_tag_select,
                 output force_hit, tag_hit);
endinterface : dbgbp_link_if

`default_nettype wire

// file: core/dbgbp_decode.sv
`default_nettype none

// Command codes reach the registers only here; there is no memory-mapped path
module dbgbp_decode (
    dbgbp_link_if.dec link
);

    assign link.do_bgnd      = link.cmd_valid && (link.cmd_code == dbgbp_pkg::CMD_BACKGROUND);
    assign link.do_rd_status = link.cmd_valid && (link.cmd_code == dbgbp_pkg::CMD_READ_STATUS);
    assign link.do_wr_ctrl   = link.cmd_valid && (link.cmd_code == dbgbp_pkg::CMD_WRITE_CONTROL);
    assign link.do_rd_match  = link.cmd_valid && (link.cmd_code == dbgbp_pkg::CMD_READ_MATCH);
    assign link.do_wr_match  = link.cmd_valid && (link.cmd_code == dbgbp_pkg::CMD_WRITE_MATCH);

endmodule // dbgbp_decode

`default_nettype wire

// file: core/dbgbp_match.sv
`default_nettype none

module dbgbp_match #(
    parameter int unsigned DEPTH = dbgbp_pkg::QUEUE_DEPTH
) (
    input  wire logic                         clk,
    input  wire logic                         sys_rst,
    input  wire logic [dbgbp_pkg::ADDR_W-1:0] cpu_addr,
    input  wire logic                         cpu_access,
    input  wire logic                         cpu_opcode_fetch,
    input  wire logic                         cpu_opcode_exec,
    input  wire logic                         cpu_queue_flush,
    dbgbp_link_if.bp                          link
);

    localparam int unsigned CNT_W = $clog2(DEPTH + 1);

    logic             hit;
    logic             pop;
    logic             push;
    logic [CNT_W-1:0] cnt_r;
    logic [CNT_W-1:0] cnt_nxt;
    logic [CNT_W-1:0] wr_idx;
    logic [DEPTH-1:0] tag_q_r;
    logic [DEPTH-1:0] tag_nxt;

    assign hit  = cpu_access && (cpu_addr == link.match_addr);
    assign pop  = cpu_opcode_exec && (cnt_r != '0);
    assign push = cpu_opcode_fetch && ((cnt_r != CNT_W'(DEPTH)) || pop);
    assign wr_idx = cnt_r - CNT_W'(pop);

    assign link.force_hit = link.bp_enable && link.force_tag_select && hit;
    // A tag left over from before a mode change is not honoured
    assign link.tag_hit = pop && tag_q_r[0] && link.bp_enable && !link.force_tag_select;

    always_comb begin
        tag_nxt = pop ? (tag_q_r >> 1) : tag_q_r;
        cnt_nxt = cnt_r - CNT_W'(pop);
        if (push) begin
            tag_nxt[wr_idx] = link.bp_enable && !link.force_tag_select && hit;
            cnt_nxt = cnt_nxt + CNT_W'(1);
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst || cpu_queue_flush) begin
            tag_q_r <= '0;
            cnt_r   <= '0;
        end else begin
            tag_q_r <= tag_nxt;
            cnt_r   <= cnt_nxt;
        end
    end

endmodule // dbgbp_match

`default_nettype wire

// file: core/dbgbp_top.sv
`default_nettype none

module dbgbp_top #(
    parameter int unsigned QUEUE_DEPTH = dbgbp_pkg::QUEUE_DEPTH
) (
    input  wire logic                         clk,
    input  wire logic                         sys_rst,
    input  wire logic                         cmd_valid,
    input  wire logic [dbgbp_pkg::CODE_W-1:0] cmd_code,
    input  wire logic [dbgbp_pkg::DATA_W-1:0] cmd_wdata,
    output var  logic                         rsp_valid,
    output var  logic [dbgbp_pkg::DATA_W-1:0] rsp_data,
    input  wire logic [dbgbp_pkg::ADDR_W-1:0] cpu_addr,
    input  wire logic                         cpu_access,
    input  wire logic                         cpu_opcode_fetch,
    input  wire logic                         cpu_opcode_exec,
    input  wire logic                         cpu_queue_flush,
    input  wire logic                         cpu_instr_boundary,
    input  wire logic                         cpu_wait_stop,
    input  wire logic                         cpu_resume,
    input  wire logic                         mem_cmd_ws_fail,
    output var  logic                         bgnd_enter,
    output var  logic                         background_active,
    output var  logic                         comm_clock_select
);

    dbgbp_link_if link ();

    logic                         permit_r;
    logic                         bkpt_enable_r;
    logic                         force_tag_r;
    logic                         clk_sel_r;
    logic [dbgbp_pkg::ADDR_W-1:0] match_r;
    logic                         bgnd_active_r;
    logic                         bgnd_enter_r;
    logic                         ws_bgnd_r;
    logic                         wsf_r;
    logic                         force_pend_r;
    logic                         rsp_valid_r;
    logic [dbgbp_pkg::DATA_W-1:0] rsp_data_r;
    logic                         enter_now;
    logic                         wait_stop_view;
    logic [dbgbp_pkg::SCR_W-1:0]  status_byte;

    assign link.cmd_valid        = cmd_valid;
    assign link.cmd_code         = cmd_code;
    assign link.match_addr       = match_r;
    assign link.bp_enable        = bkpt_enable_r;
    assign link.force_tag_select = force_tag_r;

    dbgbp_decode u_decode (
        .link (link.dec)
    );

    dbgbp_match #(
        .DEPTH (QUEUE_DEPTH)
    ) u_match (
        .clk              (clk),
        .sys_rst          (sys_rst),
        .cpu_addr         (cpu_addr),
        .cpu_access       (cpu_access),
        .cpu_opcode_fetch (cpu_opcode_fetch),
        .cpu_opcode_exec  (cpu_opcode_exec),
        .cpu_queue_flush  (cpu_queue_flush),
        .link             (link.bp)
    );

    // Any of the three sources, but only with permit and outside background
    assign enter_now = permit_r && !bgnd_active_r &&
                       ((force_pend_r && cpu_instr_boundary) ||
                        link.tag_hit ||
                        link.do_bgnd);

    assign wait_stop_view = cpu_wait_stop || ws_bgnd_r;

    always_comb begin
        status_byte = dbgbp_pkg::SCR_RESET;
        status_byte[dbgbp_pkg::BIT_PERMIT]          = permit_r;
        status_byte[dbgbp_pkg::BIT_ACTIVE]          = bgnd_active_r;
        status_byte[dbgbp_pkg::BIT_BKPT_ENABLE]     = bkpt_enable_r;
        status_byte[dbgbp_pkg::BIT_FORCE_TAG]       = force_tag_r;
        status_byte[dbgbp_pkg::BIT_CLK_SEL]         = clk_sel_r;
        status_byte[dbgbp_pkg::BIT_WAIT_STOP]       = wait_stop_view;
        status_byte[dbgbp_pkg::BIT_WAIT_STOP_FAIL]  = wsf_r;
        status_byte[dbgbp_pkg::BIT_DATA_VALID_FAIL] = 1'b0;
    end

    // Control bits; status bits have no write path here
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            permit_r      <= 1'b0;
            bkpt_enable_r <= 1'b0;
            force_tag_r   <= 1'b0;
            clk_sel_r     <= 1'b0;
        end else if (link.do_wr_ctrl) begin
            // Changing permit from inside background would be ambiguous
            if (!bgnd_active_r) begin
                permit_r <= cmd_wdata[dbgbp_pkg::BIT_PERMIT];
            end
            bkpt_enable_r <= cmd_wdata[dbgbp_pkg::BIT_BKPT_ENABLE];
            force_tag_r   <= cmd_wdata[dbgbp_pkg::BIT_FORCE_TAG];
            clk_sel_r     <= cmd_wdata[dbgbp_pkg::BIT_CLK_SEL];
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            match_r <= dbgbp_pkg::MATCH_RESET;
        end else if (link.do_wr_match) begin
            match_r <= cmd_wdata;
        end
    end

    // A forced hit waits for the next boundary; it is cleared one cycle after disable
    always_ff @(posedge clk) begin
        if (sys_rst || !bkpt_enable_r || bgnd_active_r) begin
            force_pend_r <= 1'b0;
        end else if (link.force_hit) begin
            force_pend_r <= 1'b1;
        end else if (cpu_instr_boundary) begin
            force_pend_r <= 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            bgnd_active_r <= 1'b0;
            bgnd_enter_r  <= 1'b0;
        end else begin
            bgnd_enter_r <= enter_now;
            if (enter_now) begin
                bgnd_active_r <= 1'b1;
            end else if (cpu_resume) begin
                bgnd_active_r <= 1'b0;
            end
        end
    end

    // Remembers that the background command broke a wait or stop
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            ws_bgnd_r <= 1'b0;
        end else if (enter_now && link.do_bgnd && cpu_wait_stop) begin
            ws_bgnd_r <= 1'b1;
        end else if (cpu_resume) begin
            ws_bgnd_r <= 1'b0;
        end
    end

    // Sticky until a status read; a new failure in that cycle wins
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            wsf_r <= 1'b0;
        end else if (mem_cmd_ws_fail) begin
            wsf_r <= 1'b1;
        end else if (link.do_rd_status) begin
            wsf_r <= 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            rsp_valid_r <= 1'b0;
            rsp_data_r  <= '0;
        end else begin
            rsp_valid_r <= link.do_rd_status || link.do_rd_match;
            if (link.do_rd_status) begin
                rsp_data_r <= {8'h00, status_byte};
            end else if (link.do_rd_match) begin
                rsp_data_r <= match_r;
            end
        end
    end

    assign rsp_valid         = rsp_valid_r;
    assign rsp_data          = rsp_data_r;
    assign bgnd_enter        = bgnd_enter_r;
    assign background_active = bgnd_active_r;
    assign comm_clock_select = clk_sel_r;

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (sys_rst);

    sequence s_bg_ok;
        link.do_bgnd && permit_r && !bgnd_active_r;
    endsequence

    sequence s_entered;
        bgnd_enter_r && bgnd_active_r;
    endsequence

    sequence s_ws_break;
        s_bg_ok and cpu_wait_stop;
    endsequence

    sequence s_match_rt;
        link.do_wr_match ##1 link.do_rd_match;
    endsequence

    bg_cmd_a: assert property (s_bg_ok |=> s_entered)
        else $error("background command did not enter background");

    bg_block_a: assert property (!permit_r |=> !bgnd_enter_r && !$rose(bgnd_active_r))
        else $error("background entered without permit");

    perm_lock_a: assert property (bgnd_active_r && link.do_wr_ctrl |=> $stable(permit_r))
        else $error("permit changed while in background");

    wsf_ro_a: assert property (link.do_wr_ctrl && !mem_cmd_ws_fail |=> $stable(wsf_r))
        else $error("control write altered failure status");

    act_ro_a: assert property (link.do_wr_ctrl && !enter_now && !cpu_resume
                              |=> $stable(bgnd_active_r))
        else $error("control write altered active status");

    dis_quiet_a: assert property (!bkpt_enable_r |-> !link.force_hit && !link.tag_hit)
        else $error("breakpoint requested while disabled");

    mode_sel_a: assert property (force_tag_r |-> !link.tag_hit)
        else $error("tag break in forced mode");

    force_brk_a: assert property (force_pend_r && cpu_instr_boundary && permit_r &&
                                  !bgnd_active_r |=> s_entered)
        else $error("forced breakpoint not taken at boundary");

    tag_brk_a: assert property (link.tag_hit && permit_r && !bgnd_active_r
                                |=> s_entered)
        else $error("tagged opcode not stopped");

    act_read_a: assert property (link.do_rd_status |=> rsp_valid_r &&
                    rsp_data_r[dbgbp_pkg::BIT_ACTIVE] == $past(bgnd_active_r) &&
                    !rsp_data_r[dbgbp_pkg::BIT_DATA_VALID_FAIL])
        else $error("status read shows wrong active or failure bit");

    ws_hold_a: assert property (s_ws_break ##1 (!cpu_resume) [*2]
                                |-> status_byte[dbgbp_pkg::BIT_WAIT_STOP])
        else $error("wait/stop status lost after background command");

    wsf_set_a: assert property (mem_cmd_ws_fail |=> wsf_r)
        else $error("failure status not set");

    match_rt_a: assert property (s_match_rt |=> rsp_valid_r &&
                                 rsp_data_r == $past(cmd_wdata, 2))
        else $error("match register read back wrong");

    clk_sel_a: assert property (link.do_wr_ctrl
                    |=> comm_clock_select == $past(cmd_wdata[dbgbp_pkg::BIT_CLK_SEL]))
        else $error("clock select not written");

    force_arm_a: assert property (link.force_hit && !bgnd_active_r |=> force_pend_r)
        else $error("forced hit not held for the next boundary");

    same_bnd_a: assert property (cpu_instr_boundary && !force_pend_r &&
                                 !link.tag_hit && !link.do_bgnd |=> !bgnd_enter_r)
        else $error("boundary without pending hit entered background");

    ws_read_a: assert property (link.do_rd_status && cpu_wait_stop |=>
                   rsp_data_r[dbgbp_pkg::BIT_WAIT_STOP])
        else $error("wait/stop status not reported");

    resume_a: assert property (cpu_resume && !enter_now |=> !bgnd_active_r)
        else $error("background still active after resume");

    enter_once_a: assert property (bgnd_enter_r |-> bgnd_active_r ##1 !bgnd_enter_r)
        else $error("entry pulse not single or not active");

    ctrl_write_a: assert property (link.do_wr_ctrl |=>
                      bkpt_enable_r == $past(cmd_wdata[dbgbp_pkg::BIT_BKPT_ENABLE]) &&
                      force_tag_r == $past(cmd_wdata[dbgbp_pkg::BIT_FORCE_TAG]))
        else $error("breakpoint controls not written");

    match_write_a: assert property (link.do_wr_match |=> match_r == $past(cmd_wdata))
        else $error("match register not written");

    ws_break_a: assert property (s_ws_break |=> ws_bgnd_r && bgnd_active_r)
        else $error("background command did not break wait/stop");

    bg_ignore_a: assert property (link.do_bgnd && !permit_r && !bgnd_active_r
                                  |=> !bgnd_active_r)
        else $error("background command taken without permit");

endmodule // dbgbp_top

`default_nettype wire

// file: verification/dbgbp_host_model.sv
`default_nettype none

module dbgbp_host_model (
    input  wire logic                         clk,
    output var  logic                         cmd_valid,
    output var  logic [dbgbp_pkg::CODE_W-1:0] cmd_code,
    output var  logic [dbgbp_pkg::DATA_W-1:0] cmd_wdata,
    input  wire logic                         rsp_valid,
    input  wire logic [dbgbp_pkg::DATA_W-1:0] rsp_data
);
    timeunit 1ns;
    timeprecision 1ps;

    initial begin
        cmd_valid = 1'b0;
        cmd_code  = 8'h00;
        cmd_wdata = 16'h0000;
    end

    // Idle lines carry inverted data so a stale value can never pass for a command
    task automatic send(input logic [7:0] code, input logic [15:0] wdata);
        @(negedge clk);
        cmd_valid = 1'b1;
        cmd_code  = code;
        cmd_wdata = wdata;
        @(negedge clk);
        cmd_valid = 1'b0;
        cmd_code  = ~cmd_code;
        cmd_wdata = ~cmd_wdata;
    endtask

    // Two commands in consecutive cycles; valid stays high across the boundary
    task automatic send2(input logic [7:0] code_a, input logic [15:0] wdata_a,
                         input logic [7:0] code_b, input logic [15:0] wdata_b);
        @(negedge clk);
        cmd_valid = 1'b1;
        cmd_code  = code_a;
        cmd_wdata = wdata_a;
        @(negedge clk);
        cmd_code  = code_b;
        cmd_wdata = wdata_b;
        @(negedge clk);
        cmd_valid = 1'b0;
        cmd_code  = ~cmd_code;
        cmd_wdata = ~cmd_wdata;
    endtask

    task automatic fetch(input logic [7:0] code, output logic [15:0] data, output logic ok);
        ok   = 1'b0;
        data = 16'h0000;
        send(code, 16'h0000);
        for (int i = 0; i < 3 && !ok; i++) begin
            if (rsp_valid === 1'b1) begin
                ok   = 1'b1;
                data = rsp_data;
            end else begin
                @(negedge clk);
            end
        end
    endtask

    // Recovery: pull into background, confirm it took, only then retry the command
    task automatic recover(input logic [7:0] code, input logic [15:0] wdata, output logic act);
        logic [15:0] d;
        logic        ok;
        send(dbgbp_pkg::CMD_BACKGROUND, 16'h0000);
        fetch(dbgbp_pkg::CMD_READ_STATUS, d, ok);
        act = ok & d[dbgbp_pkg::BIT_ACTIVE];
        if (act) begin
            send(code, wdata);
        end
    endtask
endmodule // dbgbp_host_model

`default_nettype wire

// file: verification/tb.sv
`default_nettype none

module tb;
    timeunit 1ns;
    timeprecision 1ps;

    localparam logic [6:0] ACC = 7'h40, FET = 7'h60, EXE = 7'h10, BND = 7'h08;
    localparam logic [6:0] FLU = 7'h04, RES = 7'h02, WAIT_STOP_FAILURE = 7'h01;

    logic        clk, sys_rst, cmd_valid, rsp_valid, bgnd_enter, background_active;
    logic        comm_clock_select, cpu_access, cpu_opcode_fetch, cpu_opcode_exec;
    logic        cpu_queue_flush, cpu_instr_boundary, cpu_wait_stop, cpu_resume;
    logic        mem_cmd_ws_fail;
    logic [7:0]  cmd_code;
    logic [15:0] cmd_wdata, rsp_data, cpu_addr;
    int          bad_count = 0;
    int          check_count = 0;

    always #5 clk = ~clk;

    dbgbp_top #(.QUEUE_DEPTH(3)) dbgbp_top_inst (
        .clk, .sys_rst, .cmd_valid, .cmd_code, .cmd_wdata, .rsp_valid, .rsp_data,
        .cpu_addr, .cpu_access, .cpu_opcode_fetch, .cpu_opcode_exec, .cpu_queue_flush,
        .cpu_instr_boundary, .cpu_wait_stop, .cpu_resume, .mem_cmd_ws_fail,
        .bgnd_enter, .background_active, .comm_clock_select
    );

    dbgbp_host_model dbgbp_host_model_inst (
        .clk, .cmd_valid, .cmd_code, .cmd_wdata, .rsp_valid, .rsp_data
    );

    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        check_count++;
        if (seen !== exp) begin
            bad_count++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic rd(input string what, input logic [7:0] code, input logic [15:0] exp);
        logic [15:0] d;
        logic        ok;
        dbgbp_host_model_inst.fetch(code, d, ok);
        check({what, " answer"}, {15'h0000, ok}, 16'h0001);
        check(what, d, exp);
    endtask

    task automatic wr(input logic [7:0] code, input logic [15:0] wdata);
        dbgbp_host_model_inst.send(code, wdata);
    endtask

    // Pulses last one cycle; the address bus shows the inverse once released
    task automatic cpu(input logic [15:0] a, input logic [6:0] f);
        @(negedge clk);
        cpu_addr = a;
        {cpu_access, cpu_opcode_fetch, cpu_opcode_exec, cpu_instr_boundary,
         cpu_queue_flush, cpu_resume, mem_cmd_ws_fail} = f;
        @(negedge clk);
        {cpu_access, cpu_opcode_fetch, cpu_opcode_exec, cpu_instr_boundary,
         cpu_queue_flush, cpu_resume, mem_cmd_ws_fail} = 7'h00;
        cpu_addr = ~a;
    endtask

    task automatic watch(input string what, input logic exp, input int n);
        logic seen;
        seen = 1'b0;
        for (int i = 0; i < n; i++) begin
            if (bgnd_enter === 1'b1) seen = 1'b1;
            @(negedge clk);
        end
        check(what, {15'h0000, seen}, {15'h0000, exp});
    endtask

    task automatic t_reset();
        rd("status at reset", 8'hE4, 16'h0000);
        rd("match at reset", 8'hE2, 16'h0000);
        check("clock select at reset", {15'h0000, comm_clock_select}, 16'h0000);
    endtask

    task automatic t_regs();
        wr(8'hC2, 16'hA55A);
        rd("match readback", 8'hE2, 16'hA55A);
        wr(8'hC4, 16'hFF4F);
        rd("status bits read-only", 8'hE4, 16'h0008);
        check("clock select set", {15'h0000, comm_clock_select}, 16'h0001);
        wr(8'hC4, 16'h0000);
        wr(8'hE0, 16'h1111);
        rd("match after unknown code", 8'hE2, 16'hA55A);
        rd("status cleared", 8'hE4, 16'h0000);
        dbgbp_host_model_inst.send2(8'hC2, 16'h5AA5, 8'hE2, 16'h0000);
        check("back to back answer", {15'h0000, rsp_valid}, 16'h0001);
        check("back to back match", rsp_data, 16'h5AA5);
    endtask

    task automatic t_forced();
        wr(8'hC2, 16'h1234);
        wr(8'hC4, 16'h0090);
        cpu(16'h1234, ACC);
        cpu(16'h0000, BND);
        watch("break while disabled", 1'b0, 4);
        wr(8'hC4, 16'h0030);
        cpu(16'h1234, ACC);
        cpu(16'h0000, BND);
        watch("break without permit", 1'b0, 4);
        wr(8'hC4, 16'h00B0);
        cpu(16'h1235, ACC);
        cpu(16'h0000, BND);
        watch("near miss address", 1'b0, 4);
        cpu(16'h1234, ACC | BND);
        watch("boundary with access", 1'b0, 3);
        cpu(16'h0000, BND);
        watch("forced entry", 1'b1, 3);
        check("active after forced", {15'h0000, background_active}, 16'h0001);
        rd("status in background", 8'hE4, 16'h00F0);
        wr(8'hC4, 16'h0038);
        rd("permit held while active", 8'hE4, 16'h00F8);
        cpu(16'h0000, RES);
        check("active after resume", {15'h0000, background_active}, 16'h0000);
        rd("status after resume", 8'hE4, 16'h00B8);
    endtask

    task automatic t_tagged();
        wr(8'hC4, 16'h00A0);
        cpu(16'h1234, ACC);
        cpu(16'h0000, BND);
        watch("no force in tag mode", 1'b0, 4);
        cpu(16'h1000, FET);
        cpu(16'h1234, FET);
        cpu(16'h0000, EXE);
        watch("untagged opcode runs", 1'b0, 3);
        cpu(16'h0000, EXE);
        watch("tagged opcode breaks", 1'b1, 3);
        cpu(16'h0000, RES);
        cpu(16'h1234, FET);
        cpu(16'h0000, FLU);
        cpu(16'h2000, FET);
        cpu(16'h0000, EXE);
        watch("tag dropped on flush", 1'b0, 3);
        cpu(16'h1234, FET);
        wr(8'hC4, 16'h0080);
        cpu(16'h0000, EXE);
        watch("tag ignored when disabled", 1'b0, 3);
    endtask

    task automatic t_wait();
        logic act;
        wr(8'hC4, 16'h0000);
        @(negedge clk);
        cpu_wait_stop = 1'b1;
        wr(8'h90, 16'h0000);
        watch("background without permit", 1'b0, 3);
        rd("status in wait", 8'hE4, 16'h0004);
        wr(8'hC4, 16'h0080);
        cpu(16'h0000, WAIT_STOP_FAILURE);
        rd("wait failure flagged", 8'hE4, 16'h0086);
        dbgbp_host_model_inst.recover(8'hE2, 16'h0000, act);
        check("background from wait", {15'h0000, act}, 16'h0001);
        @(negedge clk);
        cpu_wait_stop = 1'b0;
        rd("wait bit latched", 8'hE4, 16'h00C4);
        cpu(16'h0000, RES);
        rd("wait bit after resume", 8'hE4, 16'h0080);
    endtask

    task automatic print_verdict();
        $display("checks %0d mismatches %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    initial begin
        clk = 1'b0;
        sys_rst = 1'b1;
        cpu_addr = 16'h0000;
        {cpu_access, cpu_opcode_fetch, cpu_opcode_exec, cpu_instr_boundary,
         cpu_queue_flush, cpu_resume, mem_cmd_ws_fail, cpu_wait_stop} = 8'h00;
        repeat (5) @(negedge clk);
        sys_rst = 1'b0;
        t_reset();
        t_regs();
        t_forced();
        t_tagged();
        t_wait();
        print_verdict();
    end
endmodule // tb

`default_nettype wire
